// File: pss_assertions.sv
// port-level checks of the memory access control
`timescale 1ns/1ps
module pss_assertions (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic global_write_n_i,
  input wire logic byte_write_enable_n_i,
  input wire logic chip_select1_n_i,
  input wire logic chip_select2_i,
  input wire logic chip_select3_n_i,
  input wire logic output_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic data_lines_oe_o,
  input wire logic parity_lines_oe_o,
  input wire logic asleep_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic sel, stb, nowr, rd;
  assign sel  = !chip_select1_n_i && chip_select2_i && !chip_select3_n_i;
  assign stb  = !processor_addr_strobe_n_i && !chip_select1_n_i || !controller_addr_strobe_n_i;
  assign nowr = global_write_n_i && byte_write_enable_n_i;
  assign rd   = stb && sel && (!processor_addr_strobe_n_i || nowr);

  property p_oe_async; output_enable_n_i |-> !data_lines_oe_o; endproperty
  a_oe_async: assert property (p_oe_async) else $error("drive with enable high");
  property p_lanes; parity_lines_oe_o == data_lines_oe_o; endproperty
  a_lanes: assert property (p_lanes) else $error("parity drive differs");
  property p_desel; stb && !sel |=> !data_lines_oe_o; endproperty
  a_desel: assert property (p_desel) else $error("drive after deselect");
  property p_wr_off; processor_addr_strobe_n_i && !nowr |=> !data_lines_oe_o; endproperty
  a_wr_off: assert property (p_wr_off) else $error("drive in write cycle");
  property p_mask; stb && !sel ##1 rd |=> !data_lines_oe_o; endproperty
  a_mask: assert property (p_mask) else $error("first read cycle driven");
  property p_rd_drv;
    rd && !asleep_o ##1 !stb && nowr && !asleep_o |=> output_enable_n_i || data_lines_oe_o;
  endproperty
  a_rd_drv: assert property (p_rd_drv) else $error("read data not driven");
  property p_zz_in; sleep_request_i [*4] |-> asleep_o; endproperty
  a_zz_in: assert property (p_zz_in) else $error("sleep not entered");
  property p_zz_out; !sleep_request_i [*4] |-> !asleep_o; endproperty
  a_zz_out: assert property (p_zz_out) else $error("sleep not left");

  c_read: cover property (rd ##2 data_lines_oe_o);
  c_sleep: cover property (asleep_o);
  c_desel: cover property (stb && !sel);
endmodule : pss_assertions

bind pss_top pss_assertions u_chk (.clk_i, .reset_n_i, .processor_addr_strobe_n_i,
  .controller_addr_strobe_n_i, .global_write_n_i, .byte_write_enable_n_i, .chip_select1_n_i,
  .chip_select2_i, .chip_select3_n_i, .output_enable_n_i, .sleep_request_i,
  .data_lines_oe_o, .parity_lines_oe_o, .asleep_o);

// File: pss_host_model.sv
// far-side bus partner: resolves the shared data and parity wires
`timescale 1ns/1ps
module pss_host_model (
  input  wire logic        clk_i,
  input  wire logic        output_enable_n_i,
  input  wire logic        drive_i,
  input  wire logic [35:0] word_i,
  input  wire logic        dut_oe_i,
  input  wire logic [35:0] dut_word_i,
  output logic      [35:0] bus_o
);
  logic [35:0] last = 36'h0_0000_0000;

  // undriven wire toggles so a stale value can never pass
  always @(posedge clk_i) begin
    last <= bus_o;
  end

  always_comb begin
    if (dut_oe_i)
      bus_o = dut_word_i;
    else if (drive_i && output_enable_n_i)
      bus_o = word_i;
    else
      bus_o = ~last;
  end
endmodule : pss_host_model

// File: pss_mem.sv
// storage array, one memory per byte lane, registered read data
`timescale 1ns/1ps
module pss_mem #(
  parameter int ADDR_W = pss_pkg::ADDR_W,
  parameter int LANES  = pss_pkg::LANES,
  parameter int LANE_W = pss_pkg::LANE_W
) (
  input  wire logic clk_i,
  pss_mem_if.mem    mif
);
  import pss_pkg::*;

  logic wr_fire;

  // sleep stalls the array; the write buffer holds pending words
  assign mif.wr_ready = ~mif.sleep;
  assign wr_fire      = mif.wr_valid & ~mif.sleep;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W-1:0] lane_mem [0:(2**ADDR_W)-1];

    always_ff @(posedge clk_i) begin
      if (wr_fire && mif.wr_be[g]) begin
        lane_mem[mif.wr_addr] <= mif.wr_data[g*LANE_W +: LANE_W];
      end
    end

    logic [LANE_W-1:0] rd_lane;

    // same-edge write is forwarded so a read never sees a stale lane
    always_ff @(posedge clk_i) begin
      if (mif.rd_en) begin
        if (wr_fire && mif.wr_be[g] && (mif.wr_addr == mif.rd_addr)) begin
          rd_lane <= mif.wr_data[g*LANE_W +: LANE_W];
        end else begin
          rd_lane <= lane_mem[mif.rd_addr];
        end
      end
    end

    // one register per lane, so each slice has a single driver
    assign mif.rd_data[g*LANE_W +: LANE_W] = rd_lane;
  end
endmodule : pss_mem

// File: pss_mem_if.sv
// carrier between the access control and the storage array
`timescale 1ns/1ps
interface pss_mem_if;
  import pss_pkg::*;
  logic                   wr_valid;
  logic                   wr_ready;
  logic [ADDR_W-1:0]      wr_addr;
  logic [WORD_W-1:0]      wr_data;
  logic [LANES-1:0]       wr_be;
  logic                   rd_en;
  logic [ADDR_W-1:0]      rd_addr;
  logic [WORD_W-1:0]      rd_data;
  logic                   sleep;

  modport ctrl (output wr_valid, output wr_addr, output wr_data, output wr_be,
                output rd_en, output rd_addr, output sleep,
                input wr_ready, input rd_data);
  modport mem  (input wr_valid, input wr_addr, input wr_data, input wr_be,
                input rd_en, input rd_addr, input sleep,
                output wr_ready, output rd_data);
endinterface : pss_mem_if

// File: pss_pkg.sv
// shared constants of the pipelined synchronous static memory
package pss_pkg;
  localparam int ADDR_W  = 17;
  localparam int DATA_W  = 32;
  localparam int LANES   = 4;
  localparam int BYTE_W  = 8;
  localparam int LANE_W  = 9;
  localparam int WORD_W  = LANES * LANE_W;
  localparam int BURST_W = 2;
  localparam int BASE_W  = ADDR_W - BURST_W;
  localparam int BUF_DEPTH = 2;
  localparam int SYNC_STAGES = 2;

  localparam logic [BURST_W-1:0] BEAT_RESET  = 2'h0;
  localparam logic [BURST_W-1:0] BEAT_STEP   = 2'h1;
  localparam logic [1:0]         CNT_RESET   = 2'h0;
  localparam logic [1:0]         CNT_FULL    = 2'h2;
  localparam logic [1:0]         CNT_ONE     = 2'h1;
  localparam logic               STRAP_RESET = 1'b1;
  localparam logic [LANES-1:0]   BE_ALL      = 4'hF;
  localparam logic [LANES-1:0]   BE_NONE     = 4'h0;
endpackage : pss_pkg

// File: pss_tb_top.sv
// self-checking bench of the memory access control
`timescale 1ns/1ps
module pss_tb_top;
  import pss_pkg::*;
  localparam logic [WORD_W-1:0] ON = 36'h0_0000_0001;
  logic clk_i = 1'b0;
  logic rst_n, ps_n, cs_n, adv_n, gw_n, bwe_n, ce1_n, ce2, ce3_n, oe_n, zz, strap, hen;
  logic [ADDR_W-1:0] a;
  logic [LANES-1:0]  bs_n;
  logic [WORD_W-1:0] hw, nw, mem [0:3];
  wire  [WORD_W-1:0] bus, dw, oe_w, zz_w;
  wire               doe, poe, asleep, busy;
  int bad_count = 0;
  int n_tests = 0;

  always #25 clk_i = ~clk_i;
  assign oe_w = {35'h0_0000_0000, doe};
  assign zz_w = {35'h0_0000_0000, asleep};

  pss_top u_dut (.clk_i, .reset_n_i(rst_n), .addr_i(a), .processor_addr_strobe_n_i(ps_n),
    .controller_addr_strobe_n_i(cs_n), .burst_advance_n_i(adv_n), .global_write_n_i(gw_n),
    .byte_write_enable_n_i(bwe_n), .byte_select_n_i(bs_n), .chip_select1_n_i(ce1_n),
    .chip_select2_i(ce2), .chip_select3_n_i(ce3_n), .output_enable_n_i(oe_n),
    .sleep_request_i(zz), .burst_order_strap_i(strap), .data_lines_i(bus[31:0]),
    .data_lines_o(dw[31:0]), .data_lines_oe_o(doe), .parity_lines_i(bus[35:32]),
    .parity_lines_o(dw[35:32]), .parity_lines_oe_o(poe), .asleep_o(asleep), .busy_o(busy));
  pss_host_model u_host (.clk_i, .output_enable_n_i(oe_n), .drive_i(hen), .word_i(hw),
    .dut_oe_i(doe), .dut_word_i(dw), .bus_o(bus));

  task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic cyc;
    @(posedge clk_i);
    #2;
  endtask : cyc

  task automatic idle;
    {ps_n, cs_n, adv_n, gw_n, bwe_n, hen, ce1_n, ce2, ce3_n} = 9'h1F2;
  endtask : idle

  task automatic desel;
    cs_n = 1'b0;
    ce2 = 1'b0;
    cyc;
    chk(oe_w, '0);
    chk({35'h0_0000_0000, busy}, '0);
    idle;
  endtask : desel

  // m: chip select1 at strobe, both strobes, global write, byte write enable
  task automatic wr(input logic [1:0] ad, input logic [WORD_W-1:0] w, input logic [3:0] m,
                    input logic [3:0] bs);
    a = {15'h0000, ad};
    ps_n = 1'b0;
    ce1_n = m[3];
    cs_n = !m[2];
    gw_n = !m[2];
    oe_n = 1'b1;
    hw = w;
    hen = 1'b1;
    cyc;
    ps_n = 1'b1;
    cs_n = 1'b1;
    ce1_n = 1'b0;
    gw_n = m[1];
    bwe_n = m[0];
    bs_n = bs;
    cyc;
    desel;
  endtask : wr

  task automatic rd2(input logic [1:0] x, input logic [1:0] y);
    oe_n = 1'b0;
    a = {15'h0000, x};
    cs_n = 1'b0;
    cyc;
    chk(oe_w, '0);
    a = {15'h0000, y};
    cyc;
    chk(dw, mem[x]);
    chk(oe_w, ON);
    cs_n = 1'b1;
    cyc;
    chk(dw, mem[y]);
    oe_n = 1'b1;
    #1;
    chk(oe_w, '0);
    desel;
  endtask : rd2

  initial begin
    rst_n = 1'b0;
    idle;
    oe_n = 1'b1;
    zz = 1'b0;
    strap = 1'b1;
    a = '0;
    bs_n = 4'hF;
    hw = '0;
    repeat (16) @(posedge clk_i);
    #2;
    rst_n = 1'b1;
    cyc;
    for (int i = 0; i < 4; i++) begin
      mem[i] = ~(36'h1_2345_6789 << i);
      wr(2'(i), mem[i], 4'h0, 4'hF);
    end
    rd2(2'h0, 2'h1);
    rd2(2'h2, 2'h3);
    nw = ~mem[1];
    wr(2'h1, nw, 4'h2, 4'hA);
    mem[1] = (nw & 36'h5_00FF_00FF) | (mem[1] & ~36'h5_00FF_00FF);
    wr(2'h2, ~mem[2], 4'h3, 4'h0);
    wr(2'h3, ~mem[3], 4'h8, 4'hF);
    wr(2'h0, ~mem[0], 4'h7, 4'hF);
    rd2(2'h1, 2'h2);
    rd2(2'h3, 2'h0);
    // bursts from start 1: interleaved 1, 0, 3, then linear 1, 2, 3
    for (int m = 0; m < 2; m++) begin
      strap = (m == 0);
      repeat (4) cyc;
      oe_n = 1'b0;
      a = 17'h0_0001;
      cs_n = 1'b0;
      cyc;
      cs_n = 1'b1;
      adv_n = 1'b0;
      for (int b = 0; b < 3; b++) begin
        cyc;
        chk(dw, mem[(m == 0) ? (2'(b) ^ 2'h1) : (2'(b) + 2'h1)]);
      end
      adv_n = 1'b1;
      desel;
    end
    zz = 1'b1;
    repeat (4) cyc;
    chk(zz_w, ON);
    wr(2'h0, '0, 4'h0, 4'hF);
    zz = 1'b0;
    repeat (4) cyc;
    chk(zz_w, '0);
    rd2(2'h0, 2'h3);
    end_of_test;
  end

  // about 90 cycles expected; generous margin before giving up
  initial begin
    #(50 * 3000);
    bad_count++;
    end_of_test;
  end
endmodule : pss_tb_top

// File: pss_top.sv
// access control of the pipelined synchronous static memory
//
// Behaviour
// - sleep request idles memory, contents kept
// - write data captured into input register
// - read data appears one cycle after address
// - output enable low drives, high floats, asynchronously
// - strap low linear, high interleaved, kept static
// - inputs and read data registered on rising edge
// - either strobe starts; two-bit counter steps burst
// - global write writes all four bytes
// - processor strobe ignored while chip select1 high
// - read: strobe, selected, no write controls
// - read loads address and counter, data next edge
// - first cycle after deselect stays floating
// - back-to-back reads accepted every cycle
// - deselect with strobe floats outputs at the next edge
// - processor strobe ignores write controls, first cycle
// - processor-strobe write stores at second edge
// - byte write stores only selected bytes
// - write cycle forces data drivers off
// - both strobes: processor strobe wins
// - selected only with all three chip selects
// - counter interleaved xor or linear increment
// - byte selects act only with byte enable
`timescale 1ns/1ps
module pss_top (
  input  wire logic                          clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic [pss_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic                          processor_addr_strobe_n_i,
  input  wire logic                          controller_addr_strobe_n_i,
  input  wire logic                          burst_advance_n_i,
  input  wire logic                          global_write_n_i,
  input  wire logic                          byte_write_enable_n_i,
  input  wire logic [pss_pkg::LANES-1:0]     byte_select_n_i,
  input  wire logic                          chip_select1_n_i,
  input  wire logic                          chip_select2_i,
  input  wire logic                          chip_select3_n_i,
  input  wire logic                          output_enable_n_i,
  input  wire logic                          sleep_request_i,
  input  wire logic                          burst_order_strap_i,
  input  wire logic [pss_pkg::DATA_W-1:0]    data_lines_i,
  output logic      [pss_pkg::DATA_W-1:0]    data_lines_o,
  output logic                               data_lines_oe_o,
  input  wire logic [pss_pkg::LANES-1:0]     parity_lines_i,
  output logic      [pss_pkg::LANES-1:0]     parity_lines_o,
  output logic                               parity_lines_oe_o,
  output logic                               asleep_o,
  output logic                               busy_o
);
  import pss_pkg::*;

  pss_mem_if mif ();

  pss_mem u_mem (
    .clk_i (clk_i),
    .mif   (mif.mem)
  );

  // synchronisers (two flops for sleep, three for the strap) for the pins that do not follow the clock
  logic                sleep_meta;
  logic                asleep;
  logic                strap_meta;
  logic                strap_sync;
  logic                interleaved;

  // burst state
  logic                active;
  logic                processor_addr_strobe_n_pend;
  logic [BASE_W-1:0]   base_addr;
  logic [BURST_W-1:0]  start_low;
  logic [BURST_W-1:0]  beat;

  // read pipeline
  logic                read_pend;
  logic                drive;
  logic [WORD_W-1:0]   out_word;

  // two-entry write buffer
  logic [WORD_W-1:0]   buf_data [0:BUF_DEPTH-1];
  logic [ADDR_W-1:0]   buf_addr [0:BUF_DEPTH-1];
  logic [LANES-1:0]    buf_be   [0:BUF_DEPTH-1];
  logic                buf_wr_idx;
  logic                buf_rd_idx;
  logic [1:0]          buf_cnt;

  // decode
  logic                cs_ok;
  logic                processor_addr_strobe_n_go;
  logic                strobe;
  logic                start;
  logic                desel;
  logic                wr_req;
  logic [LANES-1:0]    wr_be;
  logic                burst_advance_n;
  logic [BURST_W-1:0]  next_beat;
  logic [BURST_W-1:0]  cur_low;
  logic [ADDR_W-1:0]   acc_addr;
  logic                acc_wr;
  logic                acc_rd;
  logic [WORD_W-1:0]   in_word;
  logic                push;
  logic                pop;
  logic                buf_full;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sleep_meta <= 1'b0;
      asleep     <= 1'b0;
    end else begin
      sleep_meta <= sleep_request_i;
      asleep     <= sleep_meta;
    end
  end

  // strap is static; it is followed only through its synchroniser
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_meta  <= STRAP_RESET;
      strap_sync  <= STRAP_RESET;
      interleaved <= STRAP_RESET;
    end else begin
      strap_meta  <= burst_order_strap_i;
      strap_sync  <= strap_meta;
      interleaved <= strap_sync;
    end
  end

  always_comb begin
    cs_ok   = ~chip_select1_n_i & chip_select2_i & ~chip_select3_n_i;
    processor_addr_strobe_n_go = ~processor_addr_strobe_n_i & ~chip_select1_n_i;
    // a valid processor strobe makes the controller strobe irrelevant
    strobe  = processor_addr_strobe_n_go | ~controller_addr_strobe_n_i;
    start   = strobe & cs_ok & ~asleep;
    desel   = strobe & ~cs_ok;
    if (!global_write_n_i) begin
      wr_be = BE_ALL;
    end else if (!byte_write_enable_n_i) begin
      wr_be = ~byte_select_n_i;
    end else begin
      wr_be = BE_NONE;
    end
    wr_req = (wr_be != BE_NONE);
    // the second edge of a processor-strobe write uses the latched address
    burst_advance_n       = ~burst_advance_n_i & ~(processor_addr_strobe_n_pend & wr_req);
    next_beat = burst_advance_n ? beat + BEAT_STEP : beat;
    cur_low   = interleaved ? (start_low ^ next_beat)
                            : (start_low + next_beat);
    if (start) begin
      acc_addr = addr_i;
      acc_wr   = ~processor_addr_strobe_n_go & wr_req;
      acc_rd   = ~acc_wr;
    end else begin
      acc_addr = {base_addr, cur_low};
      acc_wr   = active & ~desel & ~asleep & wr_req;
      acc_rd   = active & ~desel & ~asleep & ~wr_req;
    end
  end

  for (genvar g = 0; g < LANES; g++) begin : g_pack
    assign in_word[g*LANE_W +: LANE_W] =
      {parity_lines_i[g], data_lines_i[g*BYTE_W +: BYTE_W]};
    assign data_lines_o[g*BYTE_W +: BYTE_W] = out_word[g*LANE_W +: BYTE_W];
    assign parity_lines_o[g] = out_word[g*LANE_W + BYTE_W];
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      active    <= 1'b0;
      processor_addr_strobe_n_pend <= 1'b0;
      base_addr <= '0;
      start_low <= BEAT_RESET;
      beat      <= BEAT_RESET;
    end else if (asleep || desel) begin
      // accesses pending at sleep entry are abandoned
      active    <= 1'b0;
      processor_addr_strobe_n_pend <= 1'b0;
    end else if (start) begin
      active    <= 1'b1;
      processor_addr_strobe_n_pend <= processor_addr_strobe_n_go;
      base_addr <= addr_i[ADDR_W-1:BURST_W];
      start_low <= addr_i[BURST_W-1:0];
      beat      <= BEAT_RESET;
    end else if (active) begin
      processor_addr_strobe_n_pend <= 1'b0;
      beat      <= next_beat;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      read_pend <= 1'b0;
      drive     <= 1'b0;
      out_word  <= '0;
    end else begin
      read_pend <= acc_rd;
      // drive only for a word read on the previous edge, so the first
      // cycle out of the deselected state always floats
      drive <= read_pend & ~desel & ~acc_wr & ~asleep;
      if (read_pend) begin
        out_word <= mif.rd_data;
      end
    end
  end

  // the output enable pin acts without the clock; drive comes from a flop
  assign data_lines_oe_o   = drive & ~output_enable_n_i;
  assign parity_lines_oe_o = drive & ~output_enable_n_i;

  assign buf_full = (buf_cnt == CNT_FULL);
  assign push     = acc_wr & ~buf_full;
  assign pop      = (buf_cnt != CNT_RESET) & mif.wr_ready;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      buf_wr_idx <= 1'b0;
      buf_rd_idx <= 1'b0;
      buf_cnt    <= CNT_RESET;
    end else begin
      if (push) begin
        buf_wr_idx <= ~buf_wr_idx;
      end
      if (pop) begin
        buf_rd_idx <= ~buf_rd_idx;
      end
      if (push && !pop) begin
        buf_cnt <= buf_cnt + CNT_ONE;
      end else if (pop && !push) begin
        buf_cnt <= buf_cnt - CNT_ONE;
      end
    end
  end

  // entries carry no control meaning, so they need no reset
  always_ff @(posedge clk_i) begin
    if (push) begin
      buf_data[buf_wr_idx] <= in_word;
      buf_addr[buf_wr_idx] <= acc_addr;
      buf_be[buf_wr_idx]   <= wr_be;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_o   <= 1'b0;
    end else begin
      busy_o   <= (buf_cnt == CNT_FULL) | ((buf_cnt == CNT_ONE) & push & ~pop);
    end
  end

  // status shows the synchroniser's second flop, never its first
  assign asleep_o = asleep;

  assign mif.wr_valid = (buf_cnt != CNT_RESET);
  assign mif.wr_addr  = buf_addr[buf_rd_idx];
  assign mif.wr_data  = buf_data[buf_rd_idx];
  assign mif.wr_be    = buf_be[buf_rd_idx];
  assign mif.rd_en    = acc_rd;
  assign mif.rd_addr  = acc_addr;
  assign mif.sleep    = asleep;
endmodule : pss_top
